// ---- hdl/cfg_regs.svh ----
/*
  Register map, field positions, reset values and timing counts for the
  test-signal, reference/op-amp and fault-threshold configuration bank.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CFG_REGS_SVH
`define CFG_REGS_SVH

// Register indexes; byte address is four times the index
`define TEST_CFG_IDX 6'h02
`define REF_CFG_IDX 6'h03
`define FAULT_CTL_IDX 6'h04

// Stored reset values
`define TEST_CFG_RST 8'h00
`define REF_CFG_RST 8'he0
`define FAULT_CTL_RST 8'h00

// Field positions
`define TEST_SRC_BIT 4
`define TEST_AMP_BIT 2
`define TEST_RATE_LSB 0
`define REF_LEVEL_BIT 5
`define AMP_BIAS_BIT 3
`define AMP_EN_BIT 2
`define REF_STATUS_BIT 0
`define COMP_LEVEL_LSB 5

// Reserved bits forced to one or zero
`define TEST_ONES_MASK 8'he0
`define TEST_ZERO_MASK 8'h08
`define REF_ONES_MASK 8'hc0
`define REF_ZERO_MASK 8'h13
`define FAULT_ONES_MASK 8'h00
`define FAULT_ZERO_MASK 8'h1f

// Test rate codes
`define RATE_SLOW 2'h0
`define RATE_FAST 2'h1
`define RATE_UNUSED 2'h2
`define RATE_DC 2'h3

// Calibration pulse periods in master clock cycles
`define SLOW_PERIOD_CYC 2097152
`define FAST_PERIOD_CYC 1048576

// Threshold reset values (per mille) and their sum
`define HIGH_TH_RST 10'h3b6
`define LOW_TH_RST 10'h032
`define PERMILLE_FULL 11'h3e8

`endif

// ---- hdl/cfg_pkg.sv ----
/*
  Shared types of the configuration bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cfg_pkg;
  typedef logic [7:0] reg_byte_type;   // One register byte
  typedef logic [9:0] permille_type;   // Threshold in tenths of a percent
  typedef logic [1:0] rate_code_type;  // Test rate code
  typedef logic [2:0] comp_level_type; // Comparator level code
endpackage

// ---- hdl/cal_if.sv ----
/*
  Carrier between the register bank and the calibration pulse generator.
  Assumes both ends run on the same clock.
*/
interface cal_if;
  logic enable;                    // Internal test source selected
  cfg_pkg::rate_code_type rate_sel; // Requested rate
  logic wave;                      // Generated test level

  modport ctrl (output enable, output rate_sel, input wave);
  modport gen (input enable, input rate_sel, output wave);
endinterface

// ---- hdl/calib_pulse_gen.sv ----
/*
  Calibration test-signal generator: square wave at the clock divided by
  the selected period, a steady high level for dc, low otherwise.
  Assumes pclk is the master clock and ce freezes all state.
*/
`include "cfg_regs.svh"

module calib_pulse_gen #(
  parameter int SLOW_PERIOD = `SLOW_PERIOD_CYC,
  parameter int FAST_PERIOD = `FAST_PERIOD_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Control side
  cal_if.gen cal
);

  // Half periods less one, at counter width
  localparam logic [20:0] SLOW_HALF_M1 = 21'(SLOW_PERIOD / 2 - 1);
  localparam logic [20:0] FAST_HALF_M1 = 21'(FAST_PERIOD / 2 - 1);

  logic [20:0] cnt_r;   // Cycles into the current half period
  logic [20:0] half_m1; // Terminal count for the chosen rate
  logic pulsing;        // A pulsed rate is active
  logic wave_r;         // Output level
  logic wrap;           // Half period complete

  // Terminal count follows the rate code
  assign half_m1 = (cal.rate_sel == `RATE_FAST) ? FAST_HALF_M1 : SLOW_HALF_M1;
  assign pulsing = cal.enable &&
                   (cal.rate_sel == `RATE_SLOW || cal.rate_sel == `RATE_FAST);
  assign wrap = (cnt_r >= half_m1);
  assign cal.wave = wave_r;

  // Period counter; restarts whenever pulsing stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 21'h000000;
    end else if (ce) begin
      if (!pulsing || wrap) begin
        cnt_r <= 21'h000000;
      end else begin
        cnt_r <= cnt_r + 21'h000001;
      end
    end
  end

  // Output level per rate code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_r <= 1'b0;
    end else if (ce) begin
      if (!cal.enable) begin
        wave_r <= 1'b0; // External source: internal generator quiet
      end else begin
        case (cal.rate_sel)
          `RATE_SLOW, `RATE_FAST: begin
            if (wrap) begin
              wave_r <= !wave_r;
            end
          end
          `RATE_DC: begin
            wave_r <= 1'b1;
          end
          default: begin
            wave_r <= 1'b0; // Unused code
          end
        endcase
      end
    end
  end

  default clocking gen_clk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_DC_LEVEL: assert property (
    (ce && cal.enable && cal.rate_sel == `RATE_DC) |=> cal.wave
  ) else $error("dc rate did not give a high level");

  AST_EXT_QUIET: assert property (
    (ce && !cal.enable)[*2] |-> !cal.wave
  ) else $error("generator active with external source");

  COV_PULSE_EDGE: cover property (cal.enable && $rose(cal.wave));

endmodule

// ---- hdl/adc_cfg_regs.sv ----
/*
  APB register bank holding the test-signal, reference/op-amp and
  fault-threshold configuration of an eight-channel converter front end.
  Drives the analog controls and the calibration pulse generator.
  Assumes a single clock pclk at 125 MHz and an APB master on the bus.
*/
// The APB slave port was decided locally.
`include "cfg_regs.svh"

// Operation
// - Source bit: 0 external, 1 internal test
// - Amplitude bit: 0 single, 1 double calibration step
// - Rate: 00 slow, 01 fast, 11 dc
// - Reference bit: 0 gives 2.4 V, 1 gives 4 V
// - Bias bit: 0 external pin, 1 supply midpoint
// - Op-amp enable active high, resets off
// - Level code sets high-side threshold table
// - Same code sets low-side threshold table
// - Listed reserved bits always read one
// - Listed reserved bits always read zero
// - Reference bit1 reads zero, bit0 read-only status
// - Reference register resets E0h, fault 00h
module adc_cfg_regs #(
  parameter int SLOW_PERIOD = `SLOW_PERIOD_CYC, // Cycles per slow period
  parameter int FAST_PERIOD = `FAST_PERIOD_CYC  // Cycles per fast period
) (
  // Clock, reset and freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Read-only status from the analog side
  input wire logic ref_status_in,
  // Test signal controls
  output logic test_src_sel,
  output logic calib_amp_double,
  output cfg_pkg::rate_code_type calib_rate_sel,
  output logic calib_wave,
  // Reference and op-amp controls
  output logic reference_level_sel,
  output logic amp_bias_source_sel,
  output logic amp_enable,
  // Fault comparator controls
  output cfg_pkg::comp_level_type comparator_level_sel,
  output cfg_pkg::permille_type comp_high_permille,
  output cfg_pkg::permille_type comp_low_permille
);

  // Stored register bytes
  cfg_pkg::reg_byte_type test_cfg_r;  // Test signal configuration
  cfg_pkg::reg_byte_type ref_cfg_r;   // Reference and op-amp configuration
  cfg_pkg::reg_byte_type fault_ctl_r; // Fault threshold control

  // Bus decode
  logic hit_test;    // Address selects test configuration
  logic hit_ref;     // Address selects reference configuration
  logic hit_fault;   // Address selects fault control
  logic mapped;      // Any register selected
  logic done;        // Transfer completes at this edge
  logic wr_test;     // Write to test configuration
  logic wr_ref;      // Write to reference configuration
  logic wr_fault;    // Write to fault control
  logic rd_ready_r;  // Read data has been captured
  logic [31:0] prdata_r; // Captured read data

  // Threshold outputs
  cfg_pkg::permille_type high_th_r; // High-side threshold
  cfg_pkg::permille_type low_th_r;  // Low-side threshold

  // Link to the pulse generator
  cal_if cal ();

  // Word match on index, aligned addresses only
  function automatic logic addr_hit(input logic [7:0] addr, input logic [5:0] idx);
    return (addr[7:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // Forces reserved bits to their fixed levels
  function automatic cfg_pkg::reg_byte_type fix_byte(
    input cfg_pkg::reg_byte_type val,
    input cfg_pkg::reg_byte_type ones,
    input cfg_pkg::reg_byte_type zeros
  );
    return (val | ones) & ~zeros;
  endfunction

  // High-side threshold per level code, per mille
  function automatic cfg_pkg::permille_type high_permille(input cfg_pkg::comp_level_type lvl);
    case (lvl)
      3'h0: return 10'h3b6; // 95 %
      3'h1: return 10'h39d; // 92.5 %
      3'h2: return 10'h384; // 90 %
      3'h3: return 10'h36b; // 87.5 %
      3'h4: return 10'h352; // 85 %
      3'h5: return 10'h320; // 80 %
      3'h6: return 10'h2ee; // 75 %
      default: return 10'h2bc; // 70 %
    endcase
  endfunction

  // Low-side threshold per level code, per mille
  function automatic cfg_pkg::permille_type low_permille(input cfg_pkg::comp_level_type lvl);
    case (lvl)
      3'h0: return 10'h032; // 5 %
      3'h1: return 10'h04b; // 7.5 %
      3'h2: return 10'h064; // 10 %
      3'h3: return 10'h07d; // 12.5 %
      3'h4: return 10'h096; // 15 %
      3'h5: return 10'h0c8; // 20 %
      3'h6: return 10'h0fa; // 25 %
      default: return 10'h12c; // 30 %
    endcase
  endfunction

  // Address decode
  assign hit_test = addr_hit(paddr, `TEST_CFG_IDX);
  assign hit_ref = addr_hit(paddr, `REF_CFG_IDX);
  assign hit_fault = addr_hit(paddr, `FAULT_CTL_IDX);
  assign mapped = hit_test || hit_ref || hit_fault;

  // Writes finish at once; reads wait for captured data; ce low stalls
  assign pready = ce && (pwrite || rd_ready_r);
  assign pslverr = psel && penable && pready && !mapped;
  assign done = psel && penable && pready;
  assign wr_test = done && pwrite && hit_test;
  assign wr_ref = done && pwrite && hit_ref;
  assign wr_fault = done && pwrite && hit_fault;
  assign prdata = prdata_r;

  // Read-data capture flag, cleared as the read completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ready_r <= 1'b0;
    end else if (ce) begin
      rd_ready_r <= psel && !pwrite && !done;
    end
  end

  // Read data, captured from the live register state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (ce && psel && !pwrite) begin
      if (hit_test) begin
        prdata_r <= {24'h000000,
                     fix_byte(test_cfg_r, `TEST_ONES_MASK, `TEST_ZERO_MASK)};
      end else if (hit_ref) begin
        prdata_r <= {24'h000000,
                     fix_byte(ref_cfg_r, `REF_ONES_MASK, `REF_ZERO_MASK)
                     | {7'h00, ref_status_in}};
      end else if (hit_fault) begin
        prdata_r <= {24'h000000,
                     fix_byte(fault_ctl_r, `FAULT_ONES_MASK, `FAULT_ZERO_MASK)};
      end else begin
        prdata_r <= 32'h00000000; // Unmapped reads as zero
      end
    end
  end

  // Test signal configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_cfg_r <= `TEST_CFG_RST;
    end else if (ce && wr_test) begin
      test_cfg_r <= fix_byte(pwdata[7:0], `TEST_ONES_MASK, `TEST_ZERO_MASK);
    end
  end

  // Reference and op-amp configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cfg_r <= `REF_CFG_RST;
    end else if (ce && wr_ref) begin
      ref_cfg_r <= fix_byte(pwdata[7:0], `REF_ONES_MASK, `REF_ZERO_MASK);
    end
  end

  // Fault threshold control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_ctl_r <= `FAULT_CTL_RST;
    end else if (ce && wr_fault) begin
      fault_ctl_r <= fix_byte(pwdata[7:0], `FAULT_ONES_MASK, `FAULT_ZERO_MASK);
    end
  end

  // Threshold levels follow the level code one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_th_r <= `HIGH_TH_RST;
      low_th_r <= `LOW_TH_RST;
    end else if (ce) begin
      high_th_r <= high_permille(comparator_level_sel);
      low_th_r <= low_permille(comparator_level_sel);
    end
  end

  // Field outputs straight from the stored bytes; thresholds from high_th_r and low_th_r
  assign test_src_sel = test_cfg_r[`TEST_SRC_BIT];
  assign calib_amp_double = test_cfg_r[`TEST_AMP_BIT];
  assign calib_rate_sel = test_cfg_r[`TEST_RATE_LSB +: 2];
  assign reference_level_sel = ref_cfg_r[`REF_LEVEL_BIT];
  assign amp_bias_source_sel = ref_cfg_r[`AMP_BIAS_BIT];
  assign amp_enable = ref_cfg_r[`AMP_EN_BIT];
  assign comparator_level_sel = fault_ctl_r[`COMP_LEVEL_LSB +: 3];
  assign comp_high_permille = high_th_r;
  assign comp_low_permille = low_th_r;

  // Generator runs only for the internal source
  assign cal.enable = test_src_sel;
  assign cal.rate_sel = calib_rate_sel;
  assign calib_wave = cal.wave;

  // Calibration pulse generator
  calib_pulse_gen #(
    .SLOW_PERIOD(SLOW_PERIOD),
    .FAST_PERIOD(FAST_PERIOD)
  ) u_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .cal(cal.gen)
  );

  default clocking reg_clk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A read completing on the selected word
  sequence rd_done(logic hit);
    done && !pwrite && hit;
  endsequence

  AST_SRC_WRITE: assert property (
    (ce && wr_test) |=> test_src_sel == $past(pwdata[4])
  ) else $error("source bit did not take the written value");

  AST_AMP_WRITE: assert property (
    (ce && wr_test) |=> calib_amp_double == $past(pwdata[2])
  ) else $error("amplitude bit did not take the written value");

  AST_RATE_WRITE: assert property (
    (ce && wr_test) |=> calib_rate_sel == $past(pwdata[1:0])
  ) else $error("rate field did not take the written value");

  AST_REF_WRITE: assert property (
    (ce && wr_ref) |=> reference_level_sel == $past(pwdata[5])
  ) else $error("reference level bit did not take the written value");

  AST_BIAS_WRITE: assert property (
    (ce && wr_ref) |=> amp_bias_source_sel == $past(pwdata[3])
  ) else $error("bias source bit did not take the written value");

  AST_AMPEN_WRITE: assert property (
    (ce && wr_ref) |=> amp_enable == $past(pwdata[2])
  ) else $error("op-amp enable did not take the written value");

  AST_HIGH_TH: assert property (
    (ce && comparator_level_sel == 3'h3) |=> comp_high_permille == 10'h36b
  ) else $error("high threshold wrong for level three");

  AST_TH_SUM: assert property (
    (11'(comp_high_permille) + 11'(comp_low_permille)) == `PERMILLE_FULL
  ) else $error("low threshold does not mirror high threshold");

  AST_TEST_RSV_READ: assert property (
    rd_done(hit_test) |-> (prdata[7:5] == 3'h7) && !prdata[3] && (prdata[31:8] == 24'h000000)
  ) else $error("test register reserved bits read wrong");

  AST_FAULT_RSV_READ: assert property (
    rd_done(hit_fault) |-> (prdata[4:0] == 5'h00) && (prdata[31:8] == 24'h000000)
  ) else $error("fault register reserved bits read wrong");

  AST_REF_RSV_READ: assert property (
    rd_done(hit_ref) |-> (prdata[7:6] == 2'h3) && !prdata[4] && !prdata[1]
  ) else $error("reference register reserved bits read wrong");

  AST_RESET_VALUES: assert property (
    $rose(presetn) |-> reference_level_sel && !amp_enable && !amp_bias_source_sel
                       && (comparator_level_sel == 3'h0) && !test_src_sel
  ) else $error("register values after reset are wrong");

  // Refused accesses leave every stored byte as it was
  AST_UNMAPPED_IGNORED: assert property (
    (done && pwrite && !mapped) |=> $stable(test_cfg_r) && $stable(ref_cfg_r)
                                    && $stable(fault_ctl_r)
  ) else $error("unmapped write changed a register");

  // Freeze keeps every stored byte
  AST_FROZEN_HOLD: assert property (
    !ce |=> $stable(test_cfg_r) && $stable(ref_cfg_r) && $stable(fault_ctl_r)
  ) else $error("register changed while frozen");

  COV_TEST_WRITE: cover property (ce && wr_test && pwdata[4]);
  COV_REF_READ: cover property (rd_done(hit_ref));
  COV_UNMAPPED: cover property (pslverr);
  COV_DC_MODE: cover property (test_src_sel && calib_rate_sel == `RATE_DC && calib_wave);

endmodule

// ---- bench/adc_cfg_regs_tb.sv ----
/*
  Self-checking bench for the configuration register bank: drives the
  APB slave, the freeze and status inputs, and judges fields and read-back.
  Assumes the design files and cfg_regs.svh are compiled ahead of it.
*/
`include "cfg_regs.svh"

module adc_cfg_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SLOW = 16; // Shortened slow period
  localparam int FAST = 8;  // Shortened fast period
  localparam logic [7:0] A_TEST = {`TEST_CFG_IDX, 2'h0};
  localparam logic [7:0] A_REF = {`REF_CFG_IDX, 2'h0};
  localparam logic [7:0] A_FLT = {`FAULT_CTL_IDX, 2'h0};

  // Clock, reset and freeze
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  // APB
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  // Analog side
  logic ref_status_in = 1'b0;
  logic test_src_sel, calib_amp_double, calib_wave;
  cfg_pkg::rate_code_type calib_rate_sel;
  logic reference_level_sel, amp_bias_source_sel, amp_enable;
  cfg_pkg::comp_level_type comparator_level_sel;
  cfg_pkg::permille_type comp_high_permille, comp_low_permille;
  int failures = 0;
  int checks_done = 0;

  // Half period of 4 ns gives 125 MHz
  always #4 pclk = ~pclk;

  adc_cfg_regs #(.SLOW_PERIOD(SLOW), .FAST_PERIOD(FAST)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_status_in(ref_status_in),
    .test_src_sel(test_src_sel), .calib_amp_double(calib_amp_double),
    .calib_rate_sel(calib_rate_sel), .calib_wave(calib_wave),
    .reference_level_sel(reference_level_sel), .amp_bias_source_sel(amp_bias_source_sel),
    .amp_enable(amp_enable), .comparator_level_sel(comparator_level_sel),
    .comp_high_permille(comp_high_permille), .comp_low_permille(comp_low_permille)
  );

  // Prints the counts and the verdict, then stops
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Counts one comparison and reports a mismatch
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Sample pready only at rising edges, before this edge's updates land
    do begin
      @(posedge pclk);
      n++;
      if (n > 50) begin
        check(32'h1, 32'h0, "pready timeout");
        give_verdict();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  // Mapped write, answer must be clean
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, {24'h0, d}, rd, err);
    check({31'h0, err}, 32'h0, "write error flag");
  endtask

  // Mapped read compared with an expected byte
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    check(rd, {24'h0, exp}, "read data");
    check({31'h0, err}, 32'h0, "read error flag");
  endtask

  // Counts cycles between two changes of the test wave
  task automatic half_period(input int exp);
    int n;
    logic last;
    n = 0;
    last = calib_wave;
    while (calib_wave === last && n < 100) begin @(negedge pclk); n++; end
    last = calib_wave;
    n = 0;
    while (calib_wave === last && n < 100) begin @(negedge pclk); n++; end
    check(n, exp, "wave half period");
  endtask

  // Wave must stay low for a stretch
  task automatic stays_low;
    logic seen;
    seen = 1'b0;
    repeat (2 * SLOW) begin @(negedge pclk); seen = seen | (calib_wave !== 1'b0); end
    check({31'h0, seen}, 32'h0, "wave not low");
  endtask

  // Reset values of fields and read-back
  task automatic t_reset;
    check({test_src_sel, calib_amp_double, calib_rate_sel}, 32'h0, "test fields");
    check({reference_level_sel, amp_bias_source_sel, amp_enable}, 32'h4, "ref fields");
    check(comparator_level_sel, 32'h0, "level reset");
    ref_status_in <= 1'b0;
    rd_chk(A_TEST, 8'he0);
    rd_chk(A_REF, 8'he0);
    rd_chk(A_FLT, 8'h00);
  endtask

  // Reserved bits of the test register ignore wrong values
  task automatic t_test_reg;
    wr(A_TEST, 8'h1f);
    rd_chk(A_TEST, 8'hf7);
    check({test_src_sel, calib_amp_double}, 32'h3, "source and amplitude");
    wr(A_TEST, 8'he0);
    rd_chk(A_TEST, 8'he0);
    check({test_src_sel, calib_amp_double}, 32'h0, "source and amplitude off");
  endtask

  // Every rate code with the internal source, then the external source
  task automatic t_rates;
    wr(A_TEST, 8'hf0);
    check(calib_rate_sel, `RATE_SLOW, "rate slow");
    half_period(SLOW / 2);
    wr(A_TEST, 8'hf1);
    half_period(FAST / 2);
    wr(A_TEST, 8'hf3);
    @(negedge pclk);
    check({31'h0, calib_wave}, 32'h1, "dc level");
    wr(A_TEST, 8'hf2);
    check(calib_rate_sel, `RATE_UNUSED, "rate unused");
    stays_low();
    wr(A_TEST, 8'he0);
    stays_low();
  endtask

  // Reference register fields, reserved bits and status bit
  task automatic t_ref;
    ref_status_in <= 1'b1;
    wr(A_REF, 8'h3f);
    rd_chk(A_REF, 8'hed);
    check({reference_level_sel, amp_bias_source_sel, amp_enable}, 32'h7, "ref on");
    wr(A_REF, 8'hc0);
    ref_status_in <= 1'b0;
    rd_chk(A_REF, 8'hc0);
    check({reference_level_sel, amp_bias_source_sel, amp_enable}, 32'h0, "ref off");
  endtask

  // Every comparator level code and its two thresholds
  task automatic t_fault;
    cfg_pkg::permille_type hi[8];
    cfg_pkg::permille_type lo[8];
    hi = '{10'h3b6, 10'h39d, 10'h384, 10'h36b, 10'h352, 10'h320, 10'h2ee, 10'h2bc};
    lo = '{10'h032, 10'h04b, 10'h064, 10'h07d, 10'h096, 10'h0c8, 10'h0fa, 10'h12c};
    for (int c = 0; c < 8; c++) begin
      wr(A_FLT, {c[2:0], 5'h1f});
      rd_chk(A_FLT, {c[2:0], 5'h00});
      @(negedge pclk);
      check(comp_high_permille, hi[c], "high threshold");
      check(comp_low_permille, lo[c], "low threshold");
    end
  endtask

  // Unmapped and misaligned places are refused and change nothing
  task automatic t_unmapped;
    logic [31:0] rd;
    logic err;
    apb(1'b1, 8'h14, 32'hff, rd, err);
    check({31'h0, err}, 32'h1, "unmapped write flag");
    apb(1'b0, 8'h14, 32'h0, rd, err);
    check({rd[30:0], err}, 32'h1, "unmapped read");
    apb(1'b1, 8'h11, 32'h00, rd, err);
    check({31'h0, err}, 32'h1, "misaligned write flag");
    rd_chk(A_FLT, 8'he0);
  endtask

  // Freeze holds the answer back and no update lands meanwhile
  task automatic t_freeze;
    @(posedge pclk);
    ce <= 1'b0;
    fork
      wr(A_FLT, 8'h20);
      begin
        repeat (3) @(negedge pclk);
        check({31'h0, pready}, 32'h0, "pready while frozen");
        check(comparator_level_sel, 32'h7, "level while frozen");
        @(posedge pclk);
        ce <= 1'b1;
      end
    join
    check(comparator_level_sel, 32'h1, "level after freeze");
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset();
    t_test_reg();
    t_rates();
    t_ref();
    t_fault();
    t_unmapped();
    t_freeze();
    give_verdict();
  end
endmodule
